//--- core/sapc_dev.sv
// What this block does
// - Both selects low start a conversion
// - Busy low until result latched, bounded
// - Ignore convert requests while busy low
// - Busy falls within 125 ns
// - Convert within 1030 ns, data valid 1100
// - Full 12-bit word, MSB highest line
// - Two's complement code mapping preserved
// - Drive bus only read-high, selected, idle
// - Busy rises 20 to 100 ns after data
// - Select falling while idle drives last result
// - Enable during conversion waits until done
// - Read/convert falling starts, bus floats
// - Convert low at end: latch, keep floating
// - Host: trigger input last, other 10 ns
// - Select tied low works with read/convert
// - Track after conversion; 1250 ns spacing, kept by the host only
// - Host keeps bus quiet during conversion
// Purpose: Conversion control and parallel read port of the converter
// Assumes: Pins synchronous to MCLK_I; sample word supplied by analog side
// Notes: Level triggered start; sample taken at start of conversion
module sapc_dev
	import sapc_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESET_I,
	// Pins
	sapc_if.dev PINS,
	// Analog side
	input wire logic [DATA_W-1:0] SAMPLE_I,
	output logic TRACK_O
);
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_CONV = 3'b010,
		S_LAG = 3'b100
	} sapc_dev_state_e;

	typedef struct packed {
		sapc_dev_state_e st;
		logic [CNT_W-1:0] cnt;
		logic [DATA_W-1:0] hold;
		logic [DATA_W-1:0] out;
		logic busy_n;
		logic oe;
		logic track;
	} sapc_dev_s;

	sapc_dev_s r_reg;
	sapc_dev_s r_next;

	// ==========================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		unique case (r_reg.st)
			S_IDLE: begin
				// Level triggered: CS and R/C must both be low
				if (!PINS.cs_n && !PINS.rc) begin
					r_next.st = S_CONV;
					r_next.cnt = CNT_ZERO;
					r_next.hold = SAMPLE_I;
					r_next.busy_n = 1'b0;
					r_next.track = 1'b0;
				end
			end
			S_CONV: begin
				// Start requests fall through here unseen
				r_next.cnt = r_reg.cnt + CNT_ONE;
				if (r_reg.cnt == CNT_W'(CONV_CYC - 1)) begin
					r_next.st = S_LAG;
					r_next.cnt = CNT_ZERO;
					r_next.out = r_reg.hold;
					r_next.track = 1'b1;
				end
			end
			S_LAG: begin
				r_next.cnt = r_reg.cnt + CNT_ONE;
				if (r_reg.cnt == CNT_W'(BUSY_LAG_CYC - 1)) begin
					r_next.st = S_IDLE;
					r_next.busy_n = 1'b1;
				end
			end
			default: r_next = r_reg;
		endcase
		// Output drive tracks pins; a pending enable waits for idle
		r_next.oe = PINS.rc && !PINS.cs_n &&
			(r_next.st == S_IDLE);
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			r_reg.st <= S_IDLE;
			r_reg.cnt <= CNT_ZERO;
			r_reg.hold <= DATA_RST;
			r_reg.out <= DATA_RST;
			r_reg.busy_n <= 1'b1;
			r_reg.oe <= 1'b0;
			r_reg.track <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign PINS.busy_n = r_reg.busy_n;
	assign PINS.result_bus = r_reg.out;
	assign PINS.result_oe = r_reg.oe;
	assign TRACK_O = r_reg.track;
endmodule : sapc_dev

//--- core/sapc_host.sv
// Purpose: Host end that starts conversions and captures results
// Assumes: Same clock as device
// Notes: Uses R/C as trigger; CS set up first
module sapc_host
	import sapc_pkg::*;
(
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESET_I,
	// Pins
	sapc_if.host PINS,
	// User side
	input wire logic START_I,
	output logic READY_O,
	output logic DONE_O,
	output logic [DATA_W-1:0] DATA_O
);
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_SETUP = 5'b00010,
		H_PULSE = 5'b00100,
		H_WAIT = 5'b01000,
		H_READ = 5'b10000
	} sapc_host_state_e;

	typedef struct packed {
		sapc_host_state_e st;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] gap;
		logic cs_n;
		logic rc;
		logic done;
		logic ready;
		logic [DATA_W-1:0] data;
	} sapc_host_s;

	sapc_host_s r_reg;
	sapc_host_s r_next;

	// ==========================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (r_reg.gap != CNT_ZERO)
			r_next.gap = r_reg.gap - CNT_ONE;
		unique case (r_reg.st)
			H_IDLE: begin
				if (START_I && r_reg.gap == CNT_ZERO) begin
					r_next.st = H_SETUP;
					r_next.cs_n = 1'b0;
					r_next.cnt = CNT_ZERO;
				end
			end
			H_SETUP: begin
				r_next.cnt = r_reg.cnt + CNT_ONE;
				if (r_reg.cnt == CNT_W'(SETUP_CYC - 1)) begin
					r_next.st = H_PULSE;
					r_next.rc = 1'b0;
					r_next.cnt = CNT_ZERO;
					r_next.gap = CNT_W'(BETWEEN_CYC);
				end
			end
			H_PULSE: begin
				r_next.cnt = r_reg.cnt + CNT_ONE;
				if (r_reg.cnt == CNT_W'(CONV_PULSE_CYC - 1)) begin
					r_next.st = H_WAIT;
					// R/C high during busy keeps bus quiet until done
					r_next.rc = 1'b1;
				end
			end
			H_WAIT: begin
				if (PINS.busy_n && r_reg.cnt == CNT_W'(CONV_PULSE_CYC))
					r_next.cnt = r_reg.cnt;
				if (!PINS.busy_n)
					r_next.cnt = CNT_ZERO;
				else if (r_reg.cnt == CNT_ZERO)
					r_next.st = H_READ;
			end
			H_READ: begin
				if (PINS.result_oe) begin
					r_next.data = PINS.result_bus;
					r_next.done = 1'b1;
					r_next.cs_n = 1'b1;
					r_next.st = H_IDLE;
				end
			end
			default: r_next = r_reg;
		endcase
		// Ready is registered so the user side sees a flop
		r_next.ready = (r_next.st == H_IDLE) &&
			(r_next.gap == CNT_ZERO);
	end

	always_ff @(posedge MCLK_I) begin
		if (RESET_I) begin
			r_reg.st <= H_IDLE;
			r_reg.cnt <= CNT_ZERO;
			r_reg.gap <= CNT_ZERO;
			r_reg.cs_n <= 1'b1;
			r_reg.rc <= 1'b1;
			r_reg.done <= 1'b0;
			r_reg.ready <= 1'b1;
			r_reg.data <= DATA_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign PINS.cs_n = r_reg.cs_n;
	assign PINS.rc = r_reg.rc;
	assign READY_O = r_reg.ready;
	assign DONE_O = r_reg.done;
	assign DATA_O = r_reg.data;
endmodule : sapc_host

//--- core/sapc_if.sv
// Purpose: Pin bundle between converter read port and host
// Assumes: One clock; host reads the bus only while the enable is high
// Notes: Active-low pins end in _n
interface sapc_if;
	import sapc_pkg::*;
	logic cs_n;
	logic rc;
	logic busy_n;
	logic [DATA_W-1:0] result_bus;
	logic result_oe;
	modport dev (input cs_n, input rc, output busy_n,
		output result_bus, output result_oe);
	modport host (output cs_n, output rc, input busy_n,
		input result_bus, input result_oe);
endinterface : sapc_if

//--- core/sapc_pkg.sv
// Purpose: Shared constants for the converter read port and its host end
// Assumes: 125 MHz clock on both ends
// Notes: Times are in ns; cycle counts derive from them
package sapc_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_CONV_PULSE_NS = 40;
	localparam int T_BUSY_LOW_MAX_NS = 1085;
	localparam int T_BUSY_FALL_MAX_NS = 125;
	localparam int T_CONV_MAX_NS = 1030;
	localparam int T_DATA_VALID_MAX_NS = 1100;
	localparam int T_BUSY_AFTER_DV_MIN_NS = 20;
	localparam int T_SETUP_NS = 10;
	localparam int T_BETWEEN_NS = 1250;
	// Least times round up, longest times round down
	localparam int CONV_PULSE_CYC =
		(T_CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_CYC = T_CONV_MAX_NS / CLK_PERIOD_NS;
	localparam int BUSY_LAG_CYC =
		(T_BUSY_AFTER_DV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC =
		(T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BETWEEN_CYC =
		(T_BETWEEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ==========================================================
	// Data word
	localparam int DATA_W = 12;
	localparam int CNT_W = 8;
	localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
endpackage : sapc_pkg

//--- verification/sapc_checker.sv
// Purpose: Assertions on the link between device and host
// Assumes: One clock, sync active-high reset
// Notes: Watches the first interface only
module sapc_checker import sapc_pkg::*; (
	// Clock and reset
	input wire logic MCLK_I,
	input wire logic RESET_I,
	// Link
	input wire logic cs_n,
	input wire logic rc,
	input wire logic busy_n,
	input wire logic [DATA_W-1:0] result_bus,
	input wire logic result_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RESET_I);
	// ========
	// Conversion
	a_start_busy:
	assert property (busy_n && !cs_n && !rc |=> !busy_n)
		else $error("busy did not fall after start");
	a_busy_only_start:
	assert property ($fell(busy_n) |-> $past(busy_n && !cs_n && !rc))
		else $error("busy fell without start");
	a_busy_len:
	assert property ($fell(busy_n) |-> ##131 $rose(busy_n))
		else $error("busy low length wrong");
	a_result_lag:
	assert property ($changed(result_bus) |-> !busy_n[*3] ##1 busy_n)
		else $error("busy lag after data wrong");
	// ========
	// Bus enable
	a_oe_cause:
	assert property (result_oe |-> busy_n && $past(rc) && !$past(cs_n))
		else $error("bus driven outside read");
	a_oe_busy:
	assert property (!busy_n |-> !result_oe)
		else $error("bus driven during conversion");
	a_enable_idle:
	assert property (busy_n && rc && !cs_n |=> result_oe)
		else $error("bus not driven when read");
	a_bus_hold:
	assert property (result_oe |=> $stable(result_bus))
		else $error("word changed while driven");
	c_start: cover property ($fell(busy_n));
	c_read: cover property ($rose(result_oe));
	c_done_read: cover property ($rose(busy_n) && result_oe);
endmodule : sapc_checker

//--- verification/sapc_tb.sv
// Purpose: Device and host back to back, plus a bench-driven device
// Assumes: 125 MHz clock, sync reset
// Notes: Second device has select held low by the bench, raised once near the end
module sapc_tb import sapc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic MCLK_I, RESET_I, start_i, ready_o, done_o, track_b;
	logic [DATA_W-1:0] sample_i, data_o;
	int errors, cmp_count, cyc;
	sapc_if pins_a();
	sapc_if pins_b();
	sapc_dev u_sapc_dev (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
		.PINS(pins_a.dev), .SAMPLE_I(sample_i), .TRACK_O());
	sapc_dev u_sapc_dev_b (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
		.PINS(pins_b.dev), .SAMPLE_I(sample_i), .TRACK_O(track_b));
	sapc_host u_sapc_host (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
		.PINS(pins_a.host), .START_I(start_i), .READY_O(ready_o),
		.DONE_O(done_o), .DATA_O(data_o));
	sapc_checker u_sapc_checker (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
		.cs_n(pins_a.cs_n), .rc(pins_a.rc), .busy_n(pins_a.busy_n),
		.result_bus(pins_a.result_bus), .result_oe(pins_a.result_oe));
	// ========
	// Helpers
	task automatic check(string what, logic [DATA_W-1:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wrap_up();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : wrap_up
	// Host round trips over every table code
	task automatic host_codes();
		logic [DATA_W-1:0] codes [4] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
		foreach (codes[i]) begin
			do @(negedge MCLK_I); while (ready_o !== 1'b1);
			@(posedge MCLK_I);
			sample_i <= codes[i];
			start_i <= 1'b1;
			@(posedge MCLK_I);
			start_i <= 1'b0;
			do @(negedge MCLK_I); while (done_o !== 1'b1);
			check("data", data_o, codes[i]);
		end
	endtask : host_codes
	// Select held low, raised once at the end; convert held low through completion
	task automatic rc_only();
		int n;
		@(posedge MCLK_I);
		sample_i <= 12'h5A3;
		pins_b.rc <= 1'b0;
		repeat (2) @(negedge MCLK_I);
		check("oe", pins_b.result_oe, 0);
		check("track", track_b, 0);
		n = 0;
		while (pins_b.busy_n === 1'b0 && n < 200) begin
			@(negedge MCLK_I);
			n++;
		end
		check("low", DATA_W'(n), 131);
		check("track", track_b, 1);
		check("word", pins_b.result_bus, 12'h5A3);
		check("oe", pins_b.result_oe, 0);
		// Level start retriggers; raise convert on the retrigger edge
		@(posedge MCLK_I);
		pins_b.rc <= 1'b1;
		sample_i <= 12'hA5C;
		repeat (10) @(negedge MCLK_I);
		check("oe", pins_b.result_oe, 0);
		do @(negedge MCLK_I); while (pins_b.busy_n !== 1'b1);
		check("oe", pins_b.result_oe, 1);
		check("word", pins_b.result_bus, 12'h5A3);
		@(posedge MCLK_I) pins_b.cs_n <= 1'b1;
		repeat (2) @(negedge MCLK_I);
		check("oe", pins_b.result_oe, 0);
		@(posedge MCLK_I) pins_b.cs_n <= 1'b0;
		repeat (2) @(negedge MCLK_I);
		check("oe", pins_b.result_oe, 1);
	endtask : rc_only
	// ========
	// Clock, timeout and sequence
	initial begin
		MCLK_I = 1'b0;
		forever #4 MCLK_I = ~MCLK_I;
	end
	always @(posedge MCLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end
	initial begin
		{RESET_I, start_i, sample_i, pins_b.cs_n, pins_b.rc} = '0;
		{errors, cmp_count, cyc} = '0;
		RESET_I = 1'b1;
		pins_b.rc = 1'b1;
		repeat (4) @(posedge MCLK_I);
		RESET_I <= 1'b0;
		host_codes();
		rc_only();
		wrap_up();
	end
endmodule : sapc_tb
